/* design/dew_pkg.sv */
// Shared constants for the data EEPROM write controller and its core-side end
package dew_pkg;

  // Storage geometry and tick counter width
  localparam int unsigned NVM_AW          = 5;
  localparam int unsigned TICK_W          = 16;
  // Write timer length in ticks of the asynchronous timer clock
  localparam int unsigned WRITE_TICKS_DEF = 4;

  // Special function register addresses
  localparam logic [7:0] SFR_ADDR   = 8'h10;
  localparam logic [7:0] SFR_DATA   = 8'h11;
  localparam logic [7:0] SFR_BANK   = 8'h12;
  localparam logic [7:0] SFR_PTR    = 8'h13;
  localparam logic [7:0] SFR_WINDOW = 8'h14;
  localparam logic [7:0] SFR_GIE    = 8'h15;
  localparam logic [7:0] SFR_INTC   = 8'h16;

  // Control register location behind the indirect window
  localparam logic [7:0] CTRL_PTR  = 8'h40;
  localparam logic [7:0] BANK_CTRL = 8'h01;
  localparam logic [7:0] BANK_ZERO = 8'h00;

  // Control register fields
  localparam int unsigned CTRL_RSTART  = 0;
  localparam int unsigned CTRL_RPERMIT = 1;
  localparam int unsigned CTRL_WSTART  = 2;
  localparam int unsigned CTRL_WPERMIT = 3;
  localparam int unsigned CTRL_RSVD    = 7;

  // Interrupt register fields
  localparam int unsigned GIE_BIT   = 0;
  localparam int unsigned INTC_EN   = 0;
  localparam int unsigned INTC_FLAG = 1;

  // Reset values
  localparam logic [7:0] BYTE_RST = 8'h00;

  // Control values written by the core end
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] CTRL_ARM_W = 8'h08;
  localparam logic [7:0] CTRL_GO_W  = 8'h0C;
  localparam logic [7:0] CTRL_ARM_R = 8'h02;
  localparam logic [7:0] CTRL_GO_R  = 8'h03;
  localparam logic [7:0] GIE_OFF    = 8'h00;
  localparam logic [7:0] GIE_ON     = 8'h01;

  // One register access issued by the core end
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } dew_step_type;

endpackage : dew_pkg

/* design/dew_sfr_if.sv */
// Register bus and interrupt lines between the core and the EEPROM controller
`timescale 1ns/1ps
`default_nettype none
interface dew_sfr_if;
  logic       sfr_sel;
  logic       sfr_we;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic       irq_req;
  logic       irq_ack;
  logic       stack_full;

  modport core (
    output sfr_sel,
    output sfr_we,
    output sfr_addr,
    output sfr_wdata,
    input  sfr_rdata,
    input  irq_req,
    output irq_ack,
    output stack_full
  );

  modport nvm (
    input  sfr_sel,
    input  sfr_we,
    input  sfr_addr,
    input  sfr_wdata,
    output sfr_rdata,
    output irq_req,
    input  irq_ack,
    input  stack_full
  );
endinterface : dew_sfr_if
`default_nettype wire

/* design/dew_nvm.sv */
// Data EEPROM controller: registers, write timer, protection and interrupt
`timescale 1ns/1ps
`default_nettype none
module dew_nvm #(
  parameter int unsigned ADDR_W      = dew_pkg::NVM_AW,
  parameter int unsigned WRITE_TICKS = dew_pkg::WRITE_TICKS_DEF
) (
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic clk_en,
  input  wire logic timer_tick,
  output var  logic nvm_busy,
  dew_sfr_if.nvm    bus
);
  import dew_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ} dew_state_type;

  localparam int unsigned DEPTH = 2 ** ADDR_W;

  dew_state_type     state_reg;
  dew_state_type     state_next;
  logic [ADDR_W-1:0] nvm_address_reg;
  logic [7:0]        nvm_data_reg;
  logic [7:0]        bank_select_reg;
  logic [7:0]        indirect_pointer_reg;
  logic              rsvd_reg;
  logic              write_permit_reg;
  logic              write_start_reg;
  logic              read_permit_reg;
  logic              read_start_reg;
  logic              arm_reg;
  logic              global_irq_enable_reg;
  logic              nvm_irq_enable_reg;
  logic              nvm_irq_flag_reg;
  logic              irq_req_reg;
  logic [7:0]        rdata_reg;
  logic              busy_reg;
  logic              tick_s1_reg;
  logic              tick_s2_reg;
  logic              tick_s3_reg;
  logic [TICK_W-1:0] tick_cnt_reg;
  logic [7:0]        mem [DEPTH];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction : hit

  wire       bus_wr    = clk_en & bus.sfr_sel & bus.sfr_we;
  wire       bus_rd    = clk_en & bus.sfr_sel & ~bus.sfr_we;
  wire [7:0] wd        = bus.sfr_wdata;
  wire       idle      = (state_reg == ST_IDLE);
  wire       ctrl_open = hit(indirect_pointer_reg, CTRL_PTR) & hit(bank_select_reg, BANK_CTRL);
  wire       win_hit   = hit(bus.sfr_addr, SFR_WINDOW) & ctrl_open;
  wire       wr_ctrl   = bus_wr & win_hit;
  wire       wr_addr   = bus_wr & hit(bus.sfr_addr, SFR_ADDR);
  wire       wr_data   = bus_wr & hit(bus.sfr_addr, SFR_DATA);
  wire       wr_bank   = bus_wr & hit(bus.sfr_addr, SFR_BANK);
  wire       wr_ptr    = bus_wr & hit(bus.sfr_addr, SFR_PTR);
  wire       wr_gie    = bus_wr & hit(bus.sfr_addr, SFR_GIE);
  wire       wr_intc   = bus_wr & hit(bus.sfr_addr, SFR_INTC);
  wire       ack       = clk_en & bus.irq_ack;

  wire start_wr = wr_ctrl & wd[CTRL_WSTART] & ~wd[CTRL_RSTART]
                & write_permit_reg & arm_reg & idle;
  wire start_rd = wr_ctrl & wd[CTRL_RSTART] & ~wd[CTRL_WSTART]
                & read_permit_reg & idle;

  wire tick_rise = tick_s2_reg & ~tick_s3_reg;
  wire wr_done   = (state_reg == ST_WRITE) & tick_rise
                 & (tick_cnt_reg == TICK_W'(WRITE_TICKS - 1));
  wire rd_done   = clk_en & (state_reg == ST_READ);

  wire [7:0] ctrl_val = {rsvd_reg, 3'b000, write_permit_reg, write_start_reg,
                         read_permit_reg, read_start_reg};
  wire [7:0] mem_rd   = mem[nvm_address_reg];

  wire [7:0] rd_mux =
      hit(bus.sfr_addr, SFR_ADDR)   ? 8'(nvm_address_reg) :
      hit(bus.sfr_addr, SFR_DATA)   ? nvm_data_reg :
      hit(bus.sfr_addr, SFR_BANK)   ? bank_select_reg :
      hit(bus.sfr_addr, SFR_PTR)    ? indirect_pointer_reg :
      win_hit                       ? ctrl_val :
      hit(bus.sfr_addr, SFR_GIE)    ? {7'h00, global_irq_enable_reg} :
      hit(bus.sfr_addr, SFR_INTC)   ? {6'h00, nvm_irq_flag_reg, nvm_irq_enable_reg} :
                                      BYTE_RST;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (start_wr) begin
          state_next = ST_WRITE;
        end else if (start_rd) begin
          state_next = ST_READ;
        end
      end
      ST_WRITE: begin
        if (wr_done) begin
          state_next = ST_IDLE;
        end
      end
      ST_READ: begin
        if (rd_done) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  // Synchroniser advances only while clk_en is high; first stage feeds only the second
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tick_s1_reg <= 1'b0;
      tick_s2_reg <= 1'b0;
      tick_s3_reg <= 1'b0;
    end else if (clk_en) begin
      tick_s1_reg <= timer_tick;
      tick_s2_reg <= tick_s1_reg;
      tick_s3_reg <= tick_s2_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_reg <= '0;
    end else if (clk_en) begin
      if (state_reg != ST_WRITE) begin
        tick_cnt_reg <= '0;
      end else if (tick_rise) begin
        tick_cnt_reg <= tick_cnt_reg + TICK_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      busy_reg  <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      busy_reg  <= (state_next != ST_IDLE);
    end
  end

  // Array has no reset; contents survive reset like real storage
  always_ff @(posedge ref_clk) begin
    if (clk_en & wr_done) begin
      mem[nvm_address_reg] <= nvm_data_reg;
    end
  end

  // bank and pointer reset to zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      nvm_address_reg      <= '0;
      bank_select_reg      <= BYTE_RST;
      indirect_pointer_reg <= BYTE_RST;
    end else begin
      if (wr_addr) begin
        nvm_address_reg <= wd[ADDR_W-1:0];
      end
      if (wr_bank) begin
        bank_select_reg <= wd;
      end
      if (wr_ptr) begin
        indirect_pointer_reg <= wd;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      nvm_data_reg <= BYTE_RST;
    end else if (rd_done) begin
      nvm_data_reg <= mem_rd;
    end else if (wr_data) begin
      nvm_data_reg <= wd;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rsvd_reg         <= 1'b0;
      write_permit_reg <= 1'b0;
      read_permit_reg  <= 1'b0;
      arm_reg          <= 1'b0;
    end else if (clk_en) begin
      arm_reg <= wr_ctrl & wd[CTRL_WPERMIT];
      if (wr_ctrl) begin
        rsvd_reg         <= wd[CTRL_RSVD];
        write_permit_reg <= wd[CTRL_WPERMIT];
        read_permit_reg  <= wd[CTRL_RPERMIT];
      end
    end
  end

  // Start bits are set-only for software; hardware alone clears them
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      write_start_reg <= 1'b0;
      read_start_reg  <= 1'b0;
    end else if (clk_en) begin
      if (start_wr) begin
        write_start_reg <= 1'b1;
      end else if (wr_done) begin
        write_start_reg <= 1'b0;
      end
      if (start_rd) begin
        read_start_reg <= 1'b1;
      end else if (rd_done) begin
        read_start_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      global_irq_enable_reg <= 1'b0;
      nvm_irq_enable_reg    <= 1'b0;
      nvm_irq_flag_reg      <= 1'b0;
    end else if (clk_en) begin
      if (ack) begin
        global_irq_enable_reg <= 1'b0;
      end else if (wr_gie) begin
        global_irq_enable_reg <= wd[GIE_BIT];
      end
      if (wr_intc) begin
        nvm_irq_enable_reg <= wd[INTC_EN];
      end
      // set on write end, wins over clears
      if (wr_done) begin
        nvm_irq_flag_reg <= 1'b1;
      end else if (ack) begin
        nvm_irq_flag_reg <= 1'b0;
      end else if (wr_intc) begin
        nvm_irq_flag_reg <= wd[INTC_FLAG];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_req_reg <= 1'b0;
      rdata_reg   <= BYTE_RST;
    end else if (clk_en) begin
      // request gated by enables and stack
      irq_req_reg <= nvm_irq_flag_reg & nvm_irq_enable_reg & global_irq_enable_reg
                   & ~bus.stack_full & ~bus.irq_ack;
      if (bus_rd) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  assign bus.sfr_rdata = rdata_reg;
  assign bus.irq_req   = irq_req_reg;
  assign nvm_busy      = busy_reg;

endmodule : dew_nvm
`default_nettype wire

/* design/dew_core.sv */
// Core end: issues the register sequences for one EEPROM read or write
`timescale 1ns/1ps
`default_nettype none
module dew_core (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  input  wire logic       cmd_valid,
  input  wire logic       cmd_write,
  input  wire logic [4:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  input  wire logic       stack_full_in,
  output var  logic       cmd_ready,
  output var  logic       rsp_valid,
  output var  logic [7:0] rsp_data,
  output var  logic       irq_taken,
  dew_sfr_if.core         bus
);
  import dew_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE, H_STEP, H_POLL, H_WAIT, H_CHECK, H_FETCH, H_FWAIT, H_FDONE
  } dew_hstate_type;

  dew_hstate_type state_reg;
  logic           is_wr_reg;
  logic [4:0]     a_reg;
  logic [7:0]     d_reg;
  logic [3:0]     idx_reg;
  logic           sel_reg;
  logic           we_reg;
  logic [7:0]     addr_reg;
  logic [7:0]     wdata_reg;
  logic           ack_reg;
  logic           full_reg;
  logic           ready_reg;
  logic           rsp_valid_reg;
  logic [7:0]     rsp_data_reg;

  function automatic dew_step_type step(input logic w, input logic [3:0] i,
                                        input logic [4:0] a, input logic [7:0] d);
    step = '{SFR_BANK, BANK_ZERO};
    if (w) begin
      unique case (i)
        4'h0:    step = '{SFR_ADDR, 8'(a)};
        4'h1:    step = '{SFR_DATA, d};
        4'h2:    step = '{SFR_PTR, CTRL_PTR};
        4'h3:    step = '{SFR_BANK, BANK_CTRL};
        4'h4:    step = '{SFR_GIE, GIE_OFF};
        4'h5:    step = '{SFR_WINDOW, CTRL_ARM_W};
        4'h6:    step = '{SFR_WINDOW, CTRL_GO_W};
        4'h7:    step = '{SFR_GIE, GIE_ON};
        4'h8:    step = '{SFR_WINDOW, CTRL_OFF};
        default: step = '{SFR_BANK, BANK_ZERO};
      endcase
    end else begin
      unique case (i)
        4'h0:    step = '{SFR_ADDR, 8'(a)};
        4'h1:    step = '{SFR_PTR, CTRL_PTR};
        4'h2:    step = '{SFR_BANK, BANK_CTRL};
        4'h3:    step = '{SFR_WINDOW, CTRL_ARM_R};
        4'h4:    step = '{SFR_WINDOW, CTRL_GO_R};
        4'h5:    step = '{SFR_WINDOW, CTRL_OFF};
        default: step = '{SFR_BANK, BANK_ZERO};
      endcase
    end
  endfunction : step

  wire dew_step_type cur     = step(is_wr_reg, idx_reg, a_reg, d_reg);
  wire [3:0]         poll_at = is_wr_reg ? 4'h7 : 4'h4;
  wire [3:0]         last_at = is_wr_reg ? 4'h9 : 4'h6;
  wire               pending = is_wr_reg ? bus.sfr_rdata[CTRL_WSTART]
                                         : bus.sfr_rdata[CTRL_RSTART];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg     <= H_IDLE;
      is_wr_reg     <= 1'b0;
      a_reg         <= '0;
      d_reg         <= BYTE_RST;
      idx_reg       <= '0;
      sel_reg       <= 1'b0;
      we_reg        <= 1'b0;
      addr_reg      <= BYTE_RST;
      wdata_reg     <= BYTE_RST;
      ready_reg     <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg  <= BYTE_RST;
    end else if (clk_en) begin
      sel_reg       <= 1'b0;
      rsp_valid_reg <= 1'b0;
      unique case (state_reg)
        H_IDLE: begin
          ready_reg <= 1'b1;
          if (cmd_valid & ready_reg) begin
            ready_reg <= 1'b0;
            is_wr_reg <= cmd_write;
            a_reg     <= cmd_addr;
            d_reg     <= cmd_wdata;
            idx_reg   <= '0;
            state_reg <= H_STEP;
          end
        end
        // arm and start on consecutive cycles
        H_STEP: begin
          sel_reg   <= 1'b1;
          we_reg    <= 1'b1;
          addr_reg  <= cur.addr;
          wdata_reg <= cur.data;
          idx_reg   <= idx_reg + 4'h1;
          if (idx_reg == poll_at) begin
            state_reg <= H_POLL;
          end else if (idx_reg == last_at) begin
            state_reg <= is_wr_reg ? H_FDONE : H_FETCH;
          end
        end
        H_POLL: begin
          sel_reg   <= 1'b1;
          we_reg    <= 1'b0;
          addr_reg  <= SFR_WINDOW;
          state_reg <= H_WAIT;
        end
        H_WAIT: begin
          state_reg <= H_CHECK;
        end
        H_CHECK: begin
          state_reg <= pending ? H_POLL : H_STEP;
        end
        H_FETCH: begin
          sel_reg   <= 1'b1;
          we_reg    <= 1'b0;
          addr_reg  <= SFR_DATA;
          state_reg <= H_FWAIT;
        end
        H_FWAIT: begin
          state_reg <= H_FDONE;
        end
        H_FDONE: begin
          rsp_valid_reg <= 1'b1;
          rsp_data_reg  <= is_wr_reg ? d_reg : bus.sfr_rdata;
          ready_reg     <= 1'b1;
          state_reg     <= H_IDLE;
        end
      endcase
    end
  end

  // One-cycle service pulse models the vector jump
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ack_reg  <= 1'b0;
      full_reg <= 1'b0;
    end else if (clk_en) begin
      ack_reg  <= bus.irq_req & ~ack_reg;
      full_reg <= stack_full_in;
    end
  end

  assign bus.sfr_sel    = sel_reg;
  assign bus.sfr_we     = we_reg;
  assign bus.sfr_addr   = addr_reg;
  assign bus.sfr_wdata  = wdata_reg;
  assign bus.irq_ack    = ack_reg;
  assign bus.stack_full = full_reg;
  assign cmd_ready      = ready_reg;
  assign rsp_valid      = rsp_valid_reg;
  assign rsp_data       = rsp_data_reg;
  assign irq_taken      = ack_reg;

endmodule : dew_core
`default_nettype wire

/* bench/dew_sva.sv */
// Bus-level checker for the EEPROM controller end
`timescale 1ns/1ps
`default_nettype none
module dew_sva (
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       sfr_sel,
  input wire logic       sfr_we,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       irq_req,
  input wire logic       irq_ack,
  input wire logic       stack_full,
  input wire logic       nvm_busy
);
  import dew_pkg::*;
  // Generous cap: timer ticks are slow next to the bus clock
  localparam int MAX_BUSY = 120;
  logic [7:0] bank_reg;
  logic [7:0] ptr_reg;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic       wperm_reg;
  logic       rperm_reg;
  logic       arm_reg;
  logic       ien_reg;
  logic       gie_reg;
  wire logic  wr   = sfr_sel && sfr_we;
  wire logic  rd   = sfr_sel && !sfr_we;
  wire logic  win  = sfr_addr == SFR_WINDOW && bank_reg == BANK_CTRL && ptr_reg == CTRL_PTR;
  wire logic  wr_c = wr && win;
  wire logic  rd_c = rd && win;
  assign cnt_next = nvm_busy ? cnt_reg + 8'h01 : 8'h00;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bank_reg  <= BANK_ZERO;
      ptr_reg   <= BYTE_RST;
      cnt_reg   <= 8'h00;
      wperm_reg <= 1'b0;
      rperm_reg <= 1'b0;
      arm_reg   <= 1'b0;
      ien_reg   <= 1'b0;
      gie_reg   <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      arm_reg <= wr_c && sfr_wdata[CTRL_WPERMIT];
      if (wr && sfr_addr == SFR_BANK) bank_reg <= sfr_wdata;
      if (wr && sfr_addr == SFR_PTR) ptr_reg <= sfr_wdata;
      if (wr && sfr_addr == SFR_GIE) gie_reg <= sfr_wdata[GIE_BIT];
      if (wr && sfr_addr == SFR_INTC) ien_reg <= sfr_wdata[INTC_EN];
      if (wr_c) wperm_reg <= sfr_wdata[CTRL_WPERMIT];
      if (wr_c) rperm_reg <= sfr_wdata[CTRL_RPERMIT];
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_rdata_holds:
    assert property (!rd |=> $stable(sfr_rdata)) else $error("read data moved without a read");
  a_ctrl_readback:
    assert property (rd_c |=> sfr_rdata[6:4] == 3'h0 && sfr_rdata[CTRL_WPERMIT] == wperm_reg
      && sfr_rdata[CTRL_RPERMIT] == rperm_reg) else $error("control readback wrong");
  a_irq_gated:
    assert property (!(ien_reg && gie_reg) |=> !irq_req) else $error("irq without enables");
  a_start_busy:
    assert property (wr_c && sfr_wdata[CTRL_WSTART] && !sfr_wdata[CTRL_RSTART] && wperm_reg
      && arm_reg && !nvm_busy |=> nvm_busy) else $error("armed write did not start");
  a_read_cycle:
    assert property (wr_c && sfr_wdata[CTRL_RSTART] && !sfr_wdata[CTRL_WSTART] && rperm_reg
      && !nvm_busy |=> nvm_busy ##1 !nvm_busy) else $error("read cycle length wrong");
  a_write_bounded:
    assert property (cnt_reg <= MAX_BUSY) else $error("write never completed");
  a_busy_cause:
    assert property ($rose(nvm_busy) |-> $past(wr_c)) else $error("busy without control write");
  a_idle_starts_low:
    assert property (rd_c && !nvm_busy |=> !sfr_rdata[CTRL_WSTART] && !sfr_rdata[CTRL_RSTART])
      else $error("start bit high while idle");

  c_write: cover property (wr_c && sfr_wdata == CTRL_GO_W);
  c_read: cover property (wr_c && sfr_wdata == CTRL_GO_R);
  c_done: cover property ($fell(nvm_busy));
endmodule : dew_sva
`default_nettype wire

/* bench/dew_tb_top.sv */
// Testbench: core end against controller, plus a rule-breaking bus driver
`timescale 1ns/1ps
`default_nettype none
module dew_tb_top;
  import dew_pkg::*;
  localparam int unsigned WT = 2;
  logic       ref_clk   = 1'b0;
  logic       nrst      = 1'b0;
  logic       tick      = 1'b0;
  logic       en_b      = 1'b1;
  logic       cmd_valid = 1'b0;
  logic       cmd_write = 1'b0;
  logic [4:0] cmd_addr  = 5'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic       cmd_ready;
  logic       rsp_valid;
  logic       irq_taken;
  logic       busy_a;
  logic       busy_b;
  logic [7:0] rsp_data;
  int         fail_count = 0;
  int         cmp_count  = 0;
  int         cyc        = 0;
  dew_sfr_if bus_a ();
  dew_sfr_if bus_b ();

  dew_core dew_core_i (.ref_clk(ref_clk), .nrst(nrst), .clk_en(1'b1), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .stack_full_in(1'b0),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .irq_taken(irq_taken),
    .bus(bus_a.core));
  dew_nvm #(.WRITE_TICKS(WT)) dew_nvm_i (.ref_clk(ref_clk), .nrst(nrst), .clk_en(1'b1),
    .timer_tick(tick), .nvm_busy(busy_a), .bus(bus_a.nvm));
  dew_nvm #(.WRITE_TICKS(WT)) dew_nvm_i2 (.ref_clk(ref_clk), .nrst(nrst), .clk_en(en_b),
    .timer_tick(tick), .nvm_busy(busy_b), .bus(bus_b.nvm));
  dew_sva dew_sva_i (.ref_clk(ref_clk), .nrst(nrst), .sfr_sel(bus_a.sfr_sel),
    .sfr_we(bus_a.sfr_we), .sfr_addr(bus_a.sfr_addr), .sfr_wdata(bus_a.sfr_wdata),
    .sfr_rdata(bus_a.sfr_rdata), .irq_req(bus_a.irq_req), .irq_ack(bus_a.irq_ack),
    .stack_full(bus_a.stack_full), .nvm_busy(busy_a));

  always #2.5 ref_clk = ~ref_clk;
  // Timer clock unrelated in phase to the bus clock
  always #23 tick = ~tick;

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Select stays up between calls so back-to-back accesses hit adjacent edges
  task automatic b_acc(input logic we, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] rd);
    @(negedge ref_clk);
    bus_b.sfr_sel = 1'b1;
    bus_b.sfr_we = we;
    bus_b.sfr_addr = a;
    bus_b.sfr_wdata = d;
    @(posedge ref_clk);
    #1;
    rd = bus_b.sfr_rdata;
  endtask : b_acc

  task automatic b_idle();
    @(negedge ref_clk);
    bus_b.sfr_sel = 1'b0;
  endtask : b_idle

  task automatic do_cmd(input logic w, input logic [4:0] a, input logic [7:0] d,
                        output logic [7:0] rd);
    int i;
    rd = 8'hxx;
    for (i = 0; i < 100 && cmd_ready !== 1'b1; i++) @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    for (i = 0; i < 500; i++) begin
      @(negedge ref_clk);
      if (rsp_valid === 1'b1) begin
        rd = rsp_data;
        break;
      end
    end
  endtask : do_cmd

  task automatic t_reset();
    logic [7:0] rd;
    b_acc(1'b0, SFR_BANK, 8'h00, rd);
    check("bank", rd, BANK_ZERO);
    b_acc(1'b1, SFR_ADDR, 8'hFF, rd);
    b_acc(1'b0, SFR_ADDR, 8'h00, rd);
    check("addr width", rd, 8'h1F);
    b_acc(1'b1, SFR_PTR, CTRL_PTR, rd);
    b_acc(1'b1, SFR_BANK, BANK_CTRL, rd);
    b_acc(1'b0, SFR_WINDOW, 8'h00, rd);
    check("ctrl reset", rd, CTRL_OFF);
    b_idle();
  endtask : t_reset

  task automatic t_refuse();
    logic [7:0] rd;
    b_acc(1'b1, SFR_WINDOW, 8'h04, rd);
    b_acc(1'b0, SFR_WINDOW, 8'h00, rd);
    check("start unarmed", rd, CTRL_OFF);
    b_acc(1'b1, SFR_WINDOW, CTRL_ARM_W, rd);
    b_acc(1'b0, SFR_WINDOW, 8'h00, rd);
    b_acc(1'b1, SFR_WINDOW, CTRL_GO_W, rd);
    b_acc(1'b0, SFR_WINDOW, 8'h00, rd);
    check("late start", rd, CTRL_ARM_W);
    check("late busy", {7'h00, busy_b}, 8'h00);
    b_acc(1'b1, SFR_BANK, BANK_ZERO, rd);
    b_acc(1'b0, SFR_WINDOW, 8'h00, rd);
    check("hidden ctrl", rd, 8'h00);
    b_acc(1'b1, SFR_WINDOW, CTRL_OFF, rd);
    b_acc(1'b1, SFR_BANK, BANK_CTRL, rd);
    b_acc(1'b0, SFR_WINDOW, 8'h00, rd);
    check("hidden write", rd, CTRL_ARM_W);
    b_idle();
  endtask : t_refuse

  // Frozen cycle between arm and start must not break the pair
  task automatic t_freeze();
    logic [7:0] rd;
    int i;
    b_acc(1'b1, SFR_WINDOW, CTRL_ARM_W, rd);
    @(negedge ref_clk);
    en_b = 1'b0;
    bus_b.sfr_wdata = CTRL_OFF;
    @(negedge ref_clk);
    en_b = 1'b1;
    bus_b.sfr_wdata = CTRL_GO_W;
    b_idle();
    check("frozen arm", {7'h00, busy_b}, 8'h01);
    for (i = 0; i < 200 && busy_b === 1'b1; i++) @(negedge ref_clk);
    check("frozen done", {7'h00, busy_b}, 8'h00);
  endtask : t_freeze

  task automatic t_irq();
    logic [7:0] rd;
    int i;
    b_acc(1'b1, SFR_ADDR, 8'h05, rd);
    b_acc(1'b1, SFR_DATA, 8'h5A, rd);
    b_acc(1'b1, SFR_INTC, 8'h01, rd);
    b_acc(1'b1, SFR_GIE, GIE_ON, rd);
    b_acc(1'b1, SFR_WINDOW, CTRL_ARM_W, rd);
    b_acc(1'b1, SFR_WINDOW, CTRL_GO_W, rd);
    b_idle();
    check("write busy", {7'h00, busy_b}, 8'h01);
    for (i = 0; i < 200 && busy_b === 1'b1; i++) @(negedge ref_clk);
    b_acc(1'b0, SFR_WINDOW, 8'h00, rd);
    check("start cleared", rd, CTRL_ARM_W);
    b_acc(1'b0, SFR_INTC, 8'h00, rd);
    check("flag set", rd, 8'h03);
    b_idle();
    check("irq req", {7'h00, bus_b.irq_req}, 8'h01);
    bus_b.stack_full = 1'b1;
    repeat (2) @(negedge ref_clk);
    check("irq stack full", {7'h00, bus_b.irq_req}, 8'h00);
    bus_b.stack_full = 1'b0;
    repeat (2) @(negedge ref_clk);
    bus_b.irq_ack = 1'b1;
    @(negedge ref_clk);
    bus_b.irq_ack = 1'b0;
    @(negedge ref_clk);
    check("irq serviced", {7'h00, bus_b.irq_req}, 8'h00);
    b_acc(1'b0, SFR_INTC, 8'h00, rd);
    check("flag cleared", rd, 8'h01);
    b_acc(1'b0, SFR_GIE, 8'h00, rd);
    check("global cleared", rd, GIE_OFF);
    b_acc(1'b1, SFR_WINDOW, CTRL_ARM_R, rd);
    b_acc(1'b1, SFR_WINDOW, CTRL_GO_R, rd);
    // Read start drops one cycle after the request
    b_idle();
    b_acc(1'b0, SFR_WINDOW, 8'h00, rd);
    check("read done", rd, CTRL_ARM_R);
    b_acc(1'b0, SFR_DATA, 8'h00, rd);
    check("stored byte", rd, 8'h5A);
    b_idle();
  endtask : t_irq

  task automatic t_core();
    logic [7:0] rd;
    logic [4:0] adr [3] = '{5'h00, 5'h1F, 5'h0A};
    logic [7:0] dat [3] = '{8'hA5, 8'h3C, 8'hFF};
    int k;
    for (k = 0; k < 3; k++) begin
      do_cmd(1'b1, adr[k], dat[k], rd);
      check("write echo", rd, dat[k]);
    end
    for (k = 0; k < 4; k++) begin
      do_cmd(1'b0, adr[k % 3], 8'h00, rd);
      check("read back", rd, dat[k % 3]);
    end
    do_cmd(1'b0, adr[1], 8'h00, rd);
    check("repeat read", rd, dat[1]);
    // Core never sets the EEPROM interrupt enable, only the global one
    check("no irq taken", {7'h00, irq_taken}, 8'h00);
  endtask : t_core

  initial begin
    bus_b.sfr_sel = 1'b0;
    bus_b.sfr_we = 1'b0;
    bus_b.sfr_addr = 8'h00;
    bus_b.sfr_wdata = 8'h00;
    bus_b.irq_ack = 1'b0;
    bus_b.stack_full = 1'b0;
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    nrst = 1'b1;
    repeat (2) @(negedge ref_clk);
    t_reset();
    t_refuse();
    t_freeze();
    // Second reset with permit set and bank one selected
    @(negedge ref_clk);
    nrst = 1'b0;
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (2) @(negedge ref_clk);
    t_reset();
    t_irq();
    t_core();
    stop_test();
  end
endmodule : dew_tb_top
`default_nettype wire
